// ### include/rsc_pkg.sv
// Purpose: constants for the reset and stop recovery controller
// Assumes: core_clk at 125 MHz
// Notes:   reset periods are counts of core_clk cycles
package rsc_pkg;
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned RST_PERIOD_US    = 16;
	localparam int unsigned XTAL_EXTRA_US    = 40;
	localparam int unsigned RST_CYCLES       = RST_PERIOD_US * CLK_MHZ;
	localparam int unsigned XTAL_CYCLES      = (RST_PERIOD_US + XTAL_EXTRA_US) * CLK_MHZ;
	localparam int unsigned CNT_W            = 16;
	localparam logic [7:0]  UNLOCK_PATTERN   = 8'hA5;
	localparam logic [7:0]  STATUS_RESET_VAL = 8'h80;
	localparam int unsigned ST_POR           = 7;
	localparam int unsigned ST_STOP          = 6;
	localparam int unsigned ST_WDT           = 5;
	localparam int unsigned ST_EXT           = 4;
	localparam int unsigned ST_DBG           = 3;
	localparam int unsigned ST_BRN           = 2;

	typedef enum logic [1:0]
	{
		RSC_RUN  = 2'b00,
		RSC_HOLD = 2'b01,
		RSC_REL  = 2'b10
	} rsc_state_e;
endpackage

// ### rtl/rsc_reset_ctrl.sv
// Purpose: merges reset sources into system_reset and stop-recovery sources into stop_recovery
// Assumes: all inputs synchronous to core_clk
// Notes:   reset pin is open drain; pad logic resolves the wire
`timescale 1ns/1ns

// What this block does
// - device drives reset pin low while any reset is in progress
// - device only pulls pin low, otherwise releases it to pull-up
// - power-on and brown-out always cause a system reset
// - watchdog time-out resets only when response option selects reset
// - low reset pin resets only when its alternate function is enabled
// - debugger writing 1 to control bit 0 causes a system reset
// - in stop mode, watchdog time-out or enabled pin edge starts recovery
// - stop recovery runs through the same reset sequencer
// - brown-out reset asserted whenever supply below minimum safe level
// - low supply below software threshold raises interrupt, not reset
// - reset period is longer when crystal oscillator is enabled
// - debug pin is a plain input at power-up, watched during reset
// - unlock seen during reset enables debug and takes pin from gpio
// - no unlock during reset keeps debug off until next reset
// - enabled crystal overrides both crystal pins and disables their gpio
// - watchdog interrupt time-out in stop sets watchdog and stop flags
module rsc_reset_ctrl
	import rsc_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// reset sources
	input  wire logic       power_on_event,
	input  wire logic       supply_brownout,
	input  wire logic       watchdog_timeout,
	input  wire logic       watchdog_response_option,
	input  wire logic       reset_pin_alt_en,
	input  wire logic       debugger_control_reg_bit0,
	// stop mode
	input  wire logic       stop_mode,
	input  wire logic [5:0] recovery_pin_en,
	input  wire logic [5:0] port_pins_in,
	// supply monitor
	input  wire logic       supply_below_user_level,
	// options and pins
	input  wire logic       xtal_enable,
	input  wire logic       port_a_pin_zero_in,
	// reset pin (open drain, oe low drives)
	input  wire logic       reset_pin_in,
	output logic            reset_pin_out,
	output logic            reset_pin_oe_n,
	// results, and the status read that clears the flags
	output logic            system_reset,
	output logic            stop_recovery,
	output logic            low_voltage_irq,
	output logic            watchdog_irq,
	output logic [7:0]      reset_status_reg,
	output logic            debug_enable,
	output logic            port_a_pin_zero_gpio_en,
	output logic            port_a_pin_one_gpio_en,
	input  wire logic       status_read
);

	rsc_state_e       state_reg;
	rsc_state_e       state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [5:0]       pins_prev_reg;
	logic             is_stop_reg;
	logic [7:0]       unlock_sh_reg;
	logic             unlock_seen_reg;

	logic brown_req;
	logic wdt_rst_req;
	logic ext_req;
	logic dbg_req;
	logic pin_edge;
	logic stop_req;
	logic any_req;
	logic [CNT_W-1:0] period;
	logic [5:0] pins_changed;
	logic enter_hold;
	logic stop_kind;
	logic wdt_irq_req;

	// reset period, longer while the crystal starts
	function automatic logic [CNT_W-1:0] period_for(
		input logic xtal
	);
		return xtal ? CNT_W'(XTAL_CYCLES) : CNT_W'(RST_CYCLES);
	endfunction

	// last count of the hold period
	function automatic logic hold_done(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] len
	);
		return cnt >= len - CNT_W'(1);
	endfunction

	// recovery kind of a hold being entered or running, hard requests win
	function automatic logic is_stop_hold(
		input logic held_stop,
		input logic entering,
		input logic stop_ev,
		input logic hard_ev
	);
		return !hard_ev && (held_stop || (entering && stop_ev));
	endfunction

	// sticky status bit, set wins over read clear
	function automatic logic sticky(
		input logic set_ev,
		input logic cur,
		input logic clr
	);
		return set_ev || (cur && !clr);
	endfunction

	assign brown_req   = supply_brownout;
	assign wdt_rst_req = watchdog_timeout && watchdog_response_option && !stop_mode;
	// own pull-down on the pin is no request
	assign ext_req     = !reset_pin_in && reset_pin_alt_en && reset_pin_oe_n;
	assign dbg_req     = debugger_control_reg_bit0;
	assign pins_changed = (port_pins_in ^ pins_prev_reg) & recovery_pin_en;
	assign pin_edge    = |pins_changed;
	assign stop_req    = stop_mode && (watchdog_timeout || pin_edge);
	assign any_req     = power_on_event || brown_req || wdt_rst_req || ext_req || dbg_req;
	assign period      = period_for(xtal_enable);
	assign enter_hold  = (state_reg != RSC_HOLD) && (state_next == RSC_HOLD);
	assign stop_kind   = is_stop_hold(is_stop_reg, enter_hold, stop_req, any_req);
	assign wdt_irq_req = watchdog_timeout && !watchdog_response_option;

	// sequencer state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			RSC_RUN:
			begin
				if (any_req || stop_req)
					state_next = RSC_HOLD;
			end
			RSC_HOLD:
			begin
				if (!any_req && hold_done(cnt_reg, period))
					state_next = RSC_REL;
			end
			RSC_REL:
			begin
				if (any_req || stop_req)
					state_next = RSC_HOLD;
				else
					state_next = RSC_RUN;
			end
			default:
			begin
				state_next = RSC_HOLD;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_reg <= RSC_HOLD;
		else
			state_reg <= state_next;
	end

	// period counter, restarts while any hard request stands
	always_ff @(posedge core_clk)
	begin
		if (rst || state_reg != RSC_HOLD || any_req)
			cnt_reg <= '0;
		else if (cnt_reg != {CNT_W{1'b1}})
			cnt_reg <= cnt_reg + CNT_W'(1);
	end

	// recovery kind
	always_ff @(posedge core_clk)
	begin
		if (rst)
			is_stop_reg <= 1'b0;
		else if (enter_hold)
			is_stop_reg <= stop_kind;
		else if (any_req)
			is_stop_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			pins_prev_reg <= port_pins_in; // no false edge after reset
		else
			pins_prev_reg <= port_pins_in;
	end

	// outputs of the sequencer
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			system_reset  <= 1'b1;
			stop_recovery <= 1'b0;
		end
		else
		begin
			system_reset  <= (state_next == RSC_HOLD) && !stop_kind;
			stop_recovery <= (state_next == RSC_HOLD) && stop_kind;
		end
	end

	// reset pin driver, low while any hold stands
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reset_pin_oe_n <= 1'b0;
		else
			reset_pin_oe_n <= !(state_next == RSC_HOLD);
	end

	always_ff @(posedge core_clk)
	begin
		reset_pin_out <= 1'b0;
	end

	// status flags, set wins over read clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reset_status_reg <= STATUS_RESET_VAL;
		else
		begin
			reset_status_reg[ST_POR]  <= sticky(power_on_event, reset_status_reg[ST_POR], status_read);
			reset_status_reg[ST_BRN]  <= sticky(brown_req, reset_status_reg[ST_BRN], status_read);
			reset_status_reg[ST_EXT]  <= sticky(ext_req, reset_status_reg[ST_EXT], status_read);
			reset_status_reg[ST_DBG]  <= sticky(dbg_req, reset_status_reg[ST_DBG], status_read);
			reset_status_reg[ST_WDT]  <= sticky(watchdog_timeout, reset_status_reg[ST_WDT], status_read);
			reset_status_reg[ST_STOP] <= sticky(stop_req, reset_status_reg[ST_STOP], status_read);
			reset_status_reg[1:0]     <= 2'b00;
		end
	end

	// watchdog interrupt when option selects interrupt
	always_ff @(posedge core_clk)
	begin
		if (rst)
			watchdog_irq <= 1'b0;
		else
			watchdog_irq <= wdt_irq_req;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			low_voltage_irq <= 1'b0;
		else
			low_voltage_irq <= supply_below_user_level && !supply_brownout;
	end

	// debug unlock watch during reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			unlock_sh_reg   <= 8'h00;
			unlock_seen_reg <= 1'b0;
		end
		else if (state_reg == RSC_HOLD)
		begin
			unlock_sh_reg <= {unlock_sh_reg[6:0], port_a_pin_zero_in};
			if ({unlock_sh_reg[6:0], port_a_pin_zero_in} == UNLOCK_PATTERN)
				unlock_seen_reg <= 1'b1;
		end
		else if (enter_hold)
		begin
			unlock_sh_reg   <= 8'h00;
			unlock_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			debug_enable <= 1'b0;
		else if (state_reg == RSC_REL)
			debug_enable <= unlock_seen_reg;
		else if (enter_hold)
			debug_enable <= 1'b0;
	end

	// crystal pins and shared debug pin
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			port_a_pin_zero_gpio_en <= 1'b1;
			port_a_pin_one_gpio_en  <= 1'b1;
		end
		else
		begin
			port_a_pin_zero_gpio_en <= !xtal_enable && !(state_reg == RSC_REL ? unlock_seen_reg : debug_enable);
			port_a_pin_one_gpio_en  <= !xtal_enable;
		end
	end

endmodule

// ### bench/rsc_pin_model.sv
// Purpose: outside circuitry on the reset wire
// Assumes: pull-up on the wire
// Notes:   pull_low stands for a reset button
`timescale 1ns/1ns
module rsc_pin_model
(
	// pin side
	input  wire logic oe_n,
	input  wire logic out,
	input  wire logic pull_low,
	output logic      pin
);
	assign pin = ((!oe_n && !out) || pull_low) ? 1'h0 : 1'h1;
endmodule

// ### bench/rsc_checker.sv
// Purpose: port assertions for the reset controller
// Assumes: one clock, sync reset
// Notes:   bound to each instance
`timescale 1ns/1ns
module rsc_checker
	import rsc_pkg::*;
(
	input wire logic core_clk, rst, power_on_event, supply_brownout, watchdog_timeout,
	input wire logic watchdog_response_option, reset_pin_alt_en, debugger_control_reg_bit0,
	input wire logic stop_mode, supply_below_user_level, reset_pin_in, reset_pin_out,
	input wire logic reset_pin_oe_n, system_reset, stop_recovery, low_voltage_irq, watchdog_irq,
	input wire logic [7:0] reset_status_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_hard_src: assert property ((power_on_event | supply_brownout) |=> system_reset)
		else $error("supply event ignored");
	chk_wdt_reset: assert property
		((watchdog_timeout & watchdog_response_option & !stop_mode) |=> system_reset)
		else $error("watchdog reset missed");
	chk_pin_req: assert property
		((!reset_pin_in & reset_pin_alt_en & reset_pin_oe_n) |=> system_reset)
		else $error("pin request missed");
	chk_debug_reset: assert property (debugger_control_reg_bit0 |=> system_reset)
		else $error("debug reset missed");
	chk_pin_drive: assert property
		(reset_pin_oe_n == !(system_reset | stop_recovery) && !reset_pin_out)
		else $error("reset pin drive wrong");
	chk_stop_wdt: assert property
		((stop_mode & watchdog_timeout & !watchdog_response_option & !system_reset
		& !stop_recovery) |=> stop_recovery & reset_status_reg[ST_STOP] & reset_status_reg[ST_WDT])
		else $error("stop recovery wrong");
	chk_low_volt: assert property
		((supply_below_user_level & !supply_brownout & !system_reset) |-> ##[1:2] low_voltage_irq)
		else $error("low voltage irq missed");
	chk_sync_rel: assert property ($fell(system_reset) |-> $rose(reset_pin_oe_n))
		else $error("release not together");
	cover property (stop_recovery);
	cover property ($fell(system_reset));
	chk_wdt_irq: assert property
		((watchdog_timeout & !watchdog_response_option) |=> watchdog_irq)
		else $error("watchdog irq missed");
	cover property (low_voltage_irq);
	cover property (watchdog_irq);
endmodule
bind rsc_reset_ctrl rsc_checker u_chk (.*);

// ### bench/tb_top.sv
// Purpose: bench for the reset controller
// Assumes: inputs driven at the falling edge
// Notes:   pin model resolves the reset wire
`timescale 1ns/1ns
module tb_top
	import rsc_pkg::*;
;
	logic core_clk = 0, rst = 1, watchdog_response_option = 0, reset_pin_alt_en = 0;
	logic stop_mode = 0, supply_below_user_level = 0, xtal_enable = 0, port_a_pin_zero_in = 0;
	logic status_read = 0, reset_pin_in, reset_pin_out, reset_pin_oe_n, system_reset;
	logic stop_recovery, low_voltage_irq, watchdog_irq, debug_enable, unl = 0, e;
	logic port_a_pin_zero_gpio_en, port_a_pin_one_gpio_en;
	logic [4:0] src = '0;
	logic [5:0] recovery_pin_en = '0, port_pins_in = '0;
	logic [7:0] reset_status_reg;
	wire logic power_on_event, supply_brownout, watchdog_timeout, ext_low, debugger_control_reg_bit0;
	int fails = 0, n_tests = 0, cyc = 0, n;
	assign {power_on_event, supply_brownout, watchdog_timeout, ext_low, debugger_control_reg_bit0} = src;
	always #4 core_clk = ~core_clk;
	always @(negedge core_clk)
	begin
		cyc++;
		port_a_pin_zero_in <= unl & UNLOCK_PATTERN[7 - cyc % 8];
	end
	rsc_reset_ctrl dut (.*);
	rsc_pin_model pm (.oe_n(reset_pin_oe_n), .out(reset_pin_out), .pull_low(ext_low), .pin(reset_pin_in));
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test;
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task settle;
		for (n = 0; (system_reset | stop_recovery) !== 1'h0 && n < 9000; n++)
			@(negedge core_clk);
	endtask
	task hit(input int k);
		src = 5'h10 >> k;
		@(negedge core_clk);
		src = '0;
		@(negedge core_clk);
	endtask
	initial
	begin
		void'($urandom(37967));
		port_pins_in = $urandom;
		repeat (2) @(negedge core_clk);
		rst = 0;
		chk("status", reset_status_reg, STATUS_RESET_VAL);
		chk("gpio0", port_a_pin_zero_gpio_en, 8'h01);
		unl = 1;
		settle();
		chk("period", n > RST_CYCLES - 4 && n < RST_CYCLES + 4, 8'h01);
		@(negedge core_clk);
		chk("unlock", {debug_enable, port_a_pin_zero_gpio_en}, 8'h02);
		unl = 0;
		for (int i = 0; i < 10; i++)
		begin
			watchdog_response_option = i / 5;
			reset_pin_alt_en = i / 5;
			e = i % 5 < 2 || i % 5 == 4 || (i % 5 == 2 && i > 4) || (i % 5 == 3 && i > 4);
			hit(i % 5);
			chk("sysrst", system_reset, e);
			chk("pin_oe_n", reset_pin_oe_n, !e);
			settle();
		end
		chk("debug", debug_enable, 8'h00);
		supply_below_user_level = 1;
		repeat (2) @(negedge core_clk);
		chk("lvirq", {low_voltage_irq, system_reset}, 8'h02);
		supply_below_user_level = 0;
		stop_mode = 1;
		recovery_pin_en = 6'h01 << ($urandom % 6);
		port_pins_in ^= recovery_pin_en;
		repeat (2) @(negedge core_clk);
		chk("stoprec", {stop_recovery, reset_status_reg[ST_STOP]}, 8'h03);
		stop_mode = 0;
		settle();
		watchdog_response_option = 0;
		status_read = 1;
		@(negedge core_clk);
		status_read = 0;
		stop_mode = 1;
		hit(2);
		chk("wdtstop", {stop_recovery, reset_status_reg[ST_STOP], reset_status_reg[ST_WDT]}, 8'h07);
		stop_mode = 0;
		settle();
		status_read = 1;
		@(negedge core_clk);
		status_read = 0;
		xtal_enable = 1;
		repeat (2) @(negedge core_clk);
		chk("xtalpins", {port_a_pin_zero_gpio_en, port_a_pin_one_gpio_en}, 8'h00);
		hit(4);
		settle();
		chk("xperiod", n > XTAL_CYCLES - 6 && n < XTAL_CYCLES + 4, 8'h01);
		end_of_test();
	end
	initial
	begin
		#400000;
		fails++;
		end_of_test();
	end
endmodule
